// ### include/fblr_pkg.sv
// constants shared by the block lock and reset logic
package fblr_pkg;
  // ----------------------------------------------------------------
  // instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ_LOCK = 8'h3D;
  localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7E;
  localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BYTE_OPCODE = 3'h0;
  localparam logic [2:0] BYTE_ADDR_LAST = 3'h3;
  localparam logic [2:0] BYTE_SAT = 3'h7;
  localparam logic [2:0] BYTES_OPCODE_ONLY = 3'h1;
  localparam int ADDR_W = 24;
  // ----------------------------------------------------------------
  // lock storage: one bit per region, region from the top address bits
  // ----------------------------------------------------------------
  localparam int LOCK_IDX_W = 4;
  localparam int LOCK_COUNT = 16;
  localparam int LOCK_IDX_LSB = ADDR_W - LOCK_IDX_W;
  localparam logic [LOCK_COUNT-1:0] LOCK_ALL_SET = 16'hFFFF;
  localparam logic [LOCK_COUNT-1:0] LOCK_ALL_CLR = 16'h0000;
  localparam logic [2:0] BP_ALL = 3'h5;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int T_RST_RECOVERY_US = 30;
  localparam int RST_RECOVERY_CYC = T_RST_RECOVERY_US * CLK_MHZ;
  localparam int RECOV_W = 16;
endpackage : fblr_pkg

// ### include/fblr_spi_if.sv
// byte-level carrier between the serial front end and the command core
`timescale 1ns/1ps
interface fblr_spi_if;
  logic byte_stb;
  logic [7:0] byte_val;
  logic [2:0] byte_num;
  logic fall_stb;
  logic end_stb;
  logic end_clean;
  logic [2:0] end_bytes;
  modport fe (
    output byte_stb, byte_val, byte_num, fall_stb, end_stb, end_clean, end_bytes
  );
  modport core (
    input byte_stb, byte_val, byte_num, fall_stb, end_stb, end_clean, end_bytes
  );
endinterface : fblr_spi_if

// ### design/fblr_spi_rx.sv
// serial front end: clock edge detection and byte assembly
`timescale 1ns/1ps
module fblr_spi_rx (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // serial pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic serial_data_in,
  // to the core
  fblr_spi_if.fe link
);
  logic sck_q;
  logic cs_n_q;
  logic [6:0] shift_q;
  logic [2:0] bit_q;
  logic [2:0] num_q;
  logic byte_stb_q;
  logic [7:0] byte_val_q;
  logic [2:0] byte_num_q;
  logic fall_q;
  logic end_q;
  logic end_clean_q;
  logic [2:0] end_bytes_q;

  wire sck_rise = !cs_n && !sck_q && sck;
  wire sck_fall = !cs_n && sck_q && !sck;
  wire cs_rise = cs_n && !cs_n_q;
  wire byte_done = sck_rise && (bit_q == fblr_pkg::BIT_LAST);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      shift_q <= 7'h00;
      bit_q <= 3'h0;
      num_q <= 3'h0;
    end else begin
      sck_q <= sck;
      cs_n_q <= cs_n;
      if (cs_n) begin
        bit_q <= 3'h0;
        num_q <= 3'h0;
      end else if (sck_rise) begin
        shift_q <= {shift_q[5:0], serial_data_in};
        bit_q <= bit_q + 3'h1;
        if (byte_done && num_q != fblr_pkg::BYTE_SAT) begin
          num_q <= num_q + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      byte_stb_q <= 1'b0;
      byte_val_q <= 8'h00;
      byte_num_q <= 3'h0;
      fall_q <= 1'b0;
      end_q <= 1'b0;
      end_clean_q <= 1'b0;
      end_bytes_q <= 3'h0;
    end else begin
      byte_stb_q <= byte_done;
      if (byte_done) begin
        byte_val_q <= {shift_q, serial_data_in};
        byte_num_q <= num_q;
      end
      fall_q <= sck_fall;
      end_q <= cs_rise;
      end_clean_q <= (bit_q == 3'h0);
      end_bytes_q <= num_q;
    end
  end

  assign link.byte_stb = byte_stb_q;
  assign link.byte_val = byte_val_q;
  assign link.byte_num = byte_num_q;
  assign link.fall_stb = fall_q;
  assign link.end_stb = end_q;
  assign link.end_clean = end_clean_q;
  assign link.end_bytes = end_bytes_q;
endmodule : fblr_spi_rx

// ### design/fblr_lock_reset.sv
// block lock bits, global lock commands and two-step software reset
`timescale 1ns/1ps
// What this block does
// - lock bits set the array protection only while protect_scheme_select is 1.
// - with scheme select 0, protection comes from complement, granularity, top/bottom, field.
// - lock bits are volatile and all become 1 at reset.
// - lock value goes out on falling clock edges, most significant bit first.
// - returned least significant bit is 1 when locked, 0 when unlocked.
// - opcode 7Eh alone in a frame sets all locks when write enable latch is 1.
// - opcode 98h alone in a frame clears all locks when write enable latch is 1.
// - reset happens only for 66h directly followed by 99h.
// - any instruction other than 99h or a repeated 66h after 66h cancels the reset enable.
// - accepted reset aborts work and returns volatile state to power-on values.
// - after a reset all commands are ignored for about 30 us.
module fblr_lock_reset #(
  parameter int RECOVERY_CYC = fblr_pkg::RST_RECOVERY_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // serial pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic serial_data_in,
  output logic sdo,
  output logic sdo_oe,
  // status bits held elsewhere
  input wire logic write_enable_latch,
  input wire logic protect_scheme_select,
  input wire logic protect_complement,
  input wire logic sector_granularity,
  input wire logic top_bottom_select,
  input wire logic [2:0] block_protect_field,
  // protection query from the array controller
  input wire logic [fblr_pkg::ADDR_W-1:0] query_addr,
  output logic query_protected,
  // reset and lock state
  output logic device_reset,
  output logic recovery_busy,
  output logic [fblr_pkg::LOCK_COUNT-1:0] lock_bits
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [fblr_pkg::LOCK_IDX_W-1:0] region_of(
    input logic [fblr_pkg::ADDR_W-1:0] a);
    region_of = a[fblr_pkg::ADDR_W-1:fblr_pkg::LOCK_IDX_LSB];
  endfunction : region_of

  // regions covered by the status field; granularity shrinks it to one region
  function automatic logic field_covers(input logic [fblr_pkg::LOCK_IDX_W-1:0] r,
    input logic [2:0] bp, input logic sec, input logic tb);
    logic [fblr_pkg::LOCK_IDX_W:0] span;
    logic [fblr_pkg::LOCK_IDX_W-1:0] pos;
    span = 5'h00;
    pos = tb ? r : ~r;
    if (bp >= fblr_pkg::BP_ALL) span = 5'h10;
    else if (bp != 3'h0) span = 5'h01 << (bp - 3'h1);
    if (sec && bp != 3'h0) span = 5'h01;
    field_covers = ({1'b0, pos} < span);
  endfunction : field_covers

  fblr_spi_if link ();

  fblr_spi_rx u_rx (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .cs_n(cs_n),
    .sck(sck),
    .serial_data_in(serial_data_in),
    .link(link)
  );

  logic [7:0] opcode_q;
  logic [fblr_pkg::ADDR_W-1:0] addr_q;
  logic armed_q;
  logic reset_q;
  logic [fblr_pkg::RECOV_W-1:0] recov_q;
  logic busy_q;
  logic [fblr_pkg::LOCK_COUNT-1:0] lock_q;
  logic reading_q;
  logic [7:0] tx_q;
  logic sdo_q;
  logic oe_q;
  logic prot_q;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire opcode_in = link.byte_stb && link.byte_num == fblr_pkg::BYTE_OPCODE && !busy_q;
  wire reset_go = opcode_in && armed_q && link.byte_val == fblr_pkg::OP_RESET;
  wire lone_end = link.end_stb && link.end_clean && !busy_q
    && link.end_bytes == fblr_pkg::BYTES_OPCODE_ONLY;
  wire glock_go = lone_end && write_enable_latch && opcode_q == fblr_pkg::OP_GLOBAL_LOCK;
  wire gunlock_go = lone_end && write_enable_latch
    && opcode_q == fblr_pkg::OP_GLOBAL_UNLOCK;
  wire read_go = link.byte_stb && !busy_q && link.byte_num == fblr_pkg::BYTE_ADDR_LAST
    && opcode_q == fblr_pkg::OP_READ_LOCK;
  wire [fblr_pkg::ADDR_W-1:0] read_addr = {addr_q[15:0], link.byte_val};
  wire read_bit = lock_q[region_of(read_addr)];
  wire scheme_lock = lock_q[region_of(query_addr)];
  wire field_prot = field_covers(region_of(query_addr), block_protect_field,
    sector_granularity, top_bottom_select) ^ protect_complement;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      opcode_q <= 8'h00;
      addr_q <= 24'h000000;
    end else if (link.byte_stb && !busy_q) begin
      if (link.byte_num == fblr_pkg::BYTE_OPCODE) opcode_q <= link.byte_val;
      else addr_q <= {addr_q[15:0], link.byte_val};
    end
  end

  // ----------------------------------------------------------------
  // reset enable, reset pulse and recovery window
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      armed_q <= 1'b0;
      reset_q <= 1'b0;
    end else begin
      reset_q <= reset_go;
      if (opcode_in) armed_q <= (link.byte_val == fblr_pkg::OP_RESET_ENABLE);
    end
  end

  // commands during recovery are dropped, not queued
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      recov_q <= '0;
      busy_q <= 1'b0;
    end else if (reset_go) begin
      recov_q <= fblr_pkg::RECOV_W'(RECOVERY_CYC - 1);
      busy_q <= 1'b1;
    end else if (recov_q != '0) begin
      recov_q <= recov_q - 1'b1;
    end else begin
      busy_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // lock bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) lock_q <= fblr_pkg::LOCK_ALL_SET;
    else if (reset_go || glock_go) lock_q <= fblr_pkg::LOCK_ALL_SET;
    else if (gunlock_go) lock_q <= fblr_pkg::LOCK_ALL_CLR;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) prot_q <= 1'b1;
    else prot_q <= protect_scheme_select ? scheme_lock : field_prot;
  end

  // ----------------------------------------------------------------
  // lock read-out
  // ----------------------------------------------------------------
  // the byte rotates so clocks past the eighth repeat the same value
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reading_q <= 1'b0;
      tx_q <= 8'h00;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (link.end_stb || reset_go) begin
      reading_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (read_go) begin
      reading_q <= 1'b1;
      tx_q <= {7'h00, read_bit};
    end else if (reading_q && link.fall_stb) begin
      sdo_q <= tx_q[7];
      tx_q <= {tx_q[6:0], tx_q[7]};
      oe_q <= 1'b1;
    end
  end

  assign sdo = sdo_q;
  assign sdo_oe = oe_q;
  assign query_protected = prot_q;
  assign device_reset = reset_q;
  assign recovery_busy = busy_q;
  assign lock_bits = lock_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  glock_sets_a: assert property (glock_go |=> lock_q == fblr_pkg::LOCK_ALL_SET)
    else $error("global lock did not set all bits");
  gunlock_clears_a: assert property (gunlock_go && !reset_go |=> lock_q == '0)
    else $error("global unlock did not clear all bits");
  no_wel_keep_a: assert property (lone_end && !write_enable_latch && !reset_go
    |=> $stable(lock_q))
    else $error("lock bits changed without write enable");
  reset_pair_a: assert property (opcode_in && armed_q
    && link.byte_val == fblr_pkg::OP_RESET |=> device_reset ##1 !device_reset)
    else $error("armed reset opcode gave no single reset pulse");
  arm_cancel_a: assert property (opcode_in
    && link.byte_val != fblr_pkg::OP_RESET_ENABLE |=> !armed_q)
    else $error("reset enable survived another instruction");
  unarmed_reset_a: assert property (opcode_in && !armed_q |=> !device_reset)
    else $error("reset without preceding enable");
  reset_relock_a: assert property (device_reset
    |-> lock_bits == fblr_pkg::LOCK_ALL_SET && !sdo_oe)
    else $error("reset did not restore power-on lock state");
  recovery_hold_a: assert property (device_reset |-> recovery_busy [*8])
    else $error("recovery window too short");
  busy_ignore_a: assert property (busy_q && !reset_go |=> $stable(lock_q))
    else $error("command taken during recovery");
  // lock bits may change on the very edge the flag is computed, so compare one cycle on
  scheme_sel_a: assert property (protect_scheme_select
    ##1 ($stable(query_addr) && $stable(lock_q))
    |-> query_protected == lock_q[region_of(query_addr)])
    else $error("scheme select ignored lock bit");
  read_value_a: assert property (read_go && !link.end_stb
    |=> tx_q == {7'h00, $past(read_bit)})
    else $error("read-out byte not lock bit in lsb");
  read_end_a: assert property (link.end_stb |=> !sdo_oe && !reading_q)
    else $error("data output held after chip select rise");

  glock_seen_c: cover property (glock_go);
  reset_seen_c: cover property (reset_go);
  read_seen_c: cover property (reading_q && link.fall_stb ##1 sdo_oe);
endmodule : fblr_lock_reset

// ### dv/fblr_host_model.sv
// host side model: frames instructions on the serial pins and samples the reply
`timescale 1ns/1ps
module fblr_host_model (
  // clock
  input wire logic clk_sys,
  // serial pins
  output logic cs_n,
  output logic sck,
  output logic serial_data_in,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic [7:0] rd_q;
  logic oe_seen;

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    serial_data_in = 1'b0;
    rd_q = 8'h00;
    oe_seen = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wait_clk

  // ----------------------------------------------------------------
  // one frame, msb first; sck stands low outside the frame
  // ----------------------------------------------------------------
  task automatic frame(input logic [39:0] bits, input int nbits);
    int i;
    cs_n <= 1'b0;
    for (i = 0; i < nbits; i++) begin
      serial_data_in <= bits[39-i];
      // long low phase so the reply bit has settled before it is sampled
      wait_clk(5);
      // an undriven line reads as the opposite of its last bit
      rd_q = {rd_q[6:0], sdo_oe ? sdo : ~sdo};
      oe_seen = sdo_oe;
      sck <= 1'b1;
      wait_clk(2);
      sck <= 1'b0;
    end
    wait_clk(3);
    cs_n <= 1'b1;
    // released line must not keep showing the last bit
    serial_data_in <= ~serial_data_in;
    wait_clk(4);
  endtask : frame
endmodule : fblr_host_model

// ### dv/fblr_lock_reset_tb_top.sv
// self-checking bench for the block lock and software reset logic
`timescale 1ns/1ps
`define CHK(name, exp, got) begin compares++; if ((got) !== (exp)) begin fail_count++; \
  $display("FAIL %s expected %h seen %h", name, exp, got); end end
module fblr_lock_reset_tb_top;
  localparam int RECOV = 200;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic cs_n, sck, serial_data_in, sdo, sdo_oe;
  logic write_enable_latch = 1'b0;
  logic protect_scheme_select = 1'b1;
  logic protect_complement = 1'b0;
  logic sector_granularity = 1'b0;
  logic top_bottom_select = 1'b0;
  logic [2:0] block_protect_field = 3'h0;
  logic [23:0] query_addr = 24'h300000;
  logic query_protected, device_reset, recovery_busy;
  logic [15:0] lock_bits;
  int fail_count = 0;
  int compares = 0;
  int rst_seen = 0;
  int i;

  always #2.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) if (device_reset === 1'b1) rst_seen <= rst_seen + 1;

  fblr_lock_reset #(.RECOVERY_CYC(RECOV)) fblr_lock_reset_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .cs_n(cs_n), .sck(sck),
    .serial_data_in(serial_data_in), .sdo(sdo), .sdo_oe(sdo_oe),
    .write_enable_latch(write_enable_latch), .protect_scheme_select(protect_scheme_select),
    .protect_complement(protect_complement), .sector_granularity(sector_granularity),
    .top_bottom_select(top_bottom_select), .block_protect_field(block_protect_field),
    .query_addr(query_addr), .query_protected(query_protected), .device_reset(device_reset),
    .recovery_busy(recovery_busy), .lock_bits(lock_bits)
  );

  fblr_host_model fblr_host_model_i (
    .clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .serial_data_in(serial_data_in),
    .sdo(sdo), .sdo_oe(sdo_oe)
  );

  task automatic tally_and_finish;
    if (fail_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cmd(input logic [7:0] op);
    fblr_host_model_i.frame({op, 32'h00000000}, 8);
  endtask : cmd

  // ----------------------------------------------------------------
  // lock read of one region, reply byte is 00h plus the lock bit
  // ----------------------------------------------------------------
  task automatic read_lock(input logic [3:0] region, input logic exp);
    fblr_host_model_i.frame({fblr_pkg::OP_READ_LOCK, region, 20'h00000, 8'h00}, 40);
    `CHK("lock_read", {7'h00, exp}, fblr_host_model_i.rd_q)
    `CHK("oe_in_read", 1'b1, fblr_host_model_i.oe_seen)
    `CHK("oe_after_read", 1'b0, sdo_oe)
  endtask : read_lock

  task automatic query(input logic ps, input logic [2:0] bp, input logic exp);
    protect_scheme_select <= ps;
    block_protect_field <= bp;
    repeat (3) @(posedge clk_sys);
    `CHK("query_protected", exp, query_protected)
  endtask : query

  initial begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    `CHK("lock_bits_reset", fblr_pkg::LOCK_ALL_SET, lock_bits)
    query(1'b1, 3'h0, 1'b1);
    read_lock(4'h3, 1'b1);
    `CHK("lock_bits_read", fblr_pkg::LOCK_ALL_SET, lock_bits)
    cmd(fblr_pkg::OP_GLOBAL_UNLOCK);
    `CHK("unlock_no_wel", fblr_pkg::LOCK_ALL_SET, lock_bits)
    write_enable_latch <= 1'b1;
    cmd(fblr_pkg::OP_GLOBAL_UNLOCK);
    `CHK("unlock", fblr_pkg::LOCK_ALL_CLR, lock_bits)
    read_lock(4'h3, 1'b0);
    query(1'b1, fblr_pkg::BP_ALL, 1'b0);
    query(1'b0, fblr_pkg::BP_ALL, 1'b1);
    query(1'b0, 3'h0, 1'b0);
    // region 3 sits in the lowest four: covered from the bottom, not from the top
    top_bottom_select <= 1'b1;
    query(1'b0, 3'h3, 1'b1);
    top_bottom_select <= 1'b0;
    query(1'b0, 3'h3, 1'b0);
    // granularity narrows to the top region only, complement inverts the span
    sector_granularity <= 1'b1;
    protect_complement <= 1'b1;
    query(1'b0, fblr_pkg::BP_ALL, 1'b1);
    sector_granularity <= 1'b0;
    query(1'b0, fblr_pkg::BP_ALL, 1'b0);
    cmd(fblr_pkg::OP_GLOBAL_LOCK);
    `CHK("lock_all", fblr_pkg::LOCK_ALL_SET, lock_bits)
    cmd(fblr_pkg::OP_GLOBAL_UNLOCK);
    // interrupted arm: an unrelated opcode between the two steps
    cmd(fblr_pkg::OP_RESET_ENABLE);
    cmd(8'h05);
    cmd(fblr_pkg::OP_RESET);
    `CHK("no_reset_pulse", 0, rst_seen)
    `CHK("locks_kept", fblr_pkg::LOCK_ALL_CLR, lock_bits)
    // nothing in flight, so the reset sequence is safe here
    `CHK("idle_before_reset", 1'b0, recovery_busy)
    cmd(fblr_pkg::OP_RESET_ENABLE);
    cmd(fblr_pkg::OP_RESET);
    `CHK("reset_pulse", 1, rst_seen)
    `CHK("locks_after_reset", fblr_pkg::LOCK_ALL_SET, lock_bits)
    `CHK("recovery_busy", 1'b1, recovery_busy)
    cmd(fblr_pkg::OP_GLOBAL_UNLOCK);
    `CHK("unlock_in_recovery", fblr_pkg::LOCK_ALL_SET, lock_bits)
    for (i = 0; i < 1000 && recovery_busy !== 1'b0; i++) @(posedge clk_sys);
    `CHK("recovery_done", 1'b0, recovery_busy)
    cmd(fblr_pkg::OP_GLOBAL_UNLOCK);
    `CHK("unlock_after_recovery", fblr_pkg::LOCK_ALL_CLR, lock_bits)
    // a pin reset in mid-run relocks and drops a pending reset enable
    cmd(fblr_pkg::OP_RESET_ENABLE);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK("locks_in_reset", fblr_pkg::LOCK_ALL_SET, lock_bits)
    reset_n <= 1'b1;
    @(posedge clk_sys);
    cmd(fblr_pkg::OP_RESET);
    `CHK("no_pulse_after_pin_reset", 1, rst_seen)
    read_lock(4'h3, 1'b1);
    tally_and_finish();
  end

  // whole run is under two thousand cycles; this cuts a hang short
  initial begin
    repeat (50000) @(posedge clk_sys);
    fail_count++;
    tally_and_finish();
  end
endmodule : fblr_lock_reset_tb_top
